// *** spi_nv_pkg.sv ***
package spi_nv_pkg;
  localparam int ADDR_W    = 16;
  localparam int MEM_DEPTH = 65536;
  localparam int BYTE_W    = 8;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_MSB  = 3'h7;

  // op-codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // status byte layout
  localparam int SR_WPEN = 7;
  localparam int SR_BP1  = 3;
  localparam int SR_BP0  = 2;
  localparam int SR_WEL  = 1;
  localparam logic [7:0] SR_FIXED = 8'h40;

  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_DATA,
    PH_STAT_IN,
    PH_STAT_OUT,
    PH_IGNORE
  } phase_t;

  // per-frame state, cleared whenever the device is deselected
  typedef struct packed {
    phase_t              phase;
    logic [2:0]          bits;
    logic [7:0]          shift;
    logic [7:0]          opcode;
    logic [ADDR_W-1:0]   addr;
    logic [7:0]          rd_byte;
  } frame_t;

  // state that survives deselection
  typedef struct packed {
    logic                wel;
    logic                wpen;
    logic [1:0]          bp;
    logic                wr_pend;
    logic                wr_tog;
    logic [ADDR_W-1:0]   last_addr;
    logic [7:0]          last_data;
  } keep_t;

  typedef struct packed {
    logic                q;
    logic                oe;
  } out_t;

  typedef struct packed {
    logic [1:0]          cs_sync;
    logic [2:0]          tog_sync;
    logic                wr_pulse;
    logic [ADDR_W-1:0]   wr_addr;
    logic [7:0]          wr_data;
  } sys_t;
endpackage

// *** spi_nv_memory_slave_port.sv ***
// What this block does
// - device-select is active low; only while low does the device respond.
// - while deselected, ignore other inputs and tristate the serial output.
// - capture inputs on rising serial clock, change output on falling clock.
// - serial clock may stop or run up to 40 MHz; state is kept.
// - while pause is low, suspend and ignore clock and select transitions.
// - protect low refuses status writes; memory writes are unaffected.
// - serial input is sampled only at rising clock edges.
// - serial output driven only for read data and status; tristate otherwise and during pause.
// - memory array of 65,536 individually reachable bytes.
// - memory accesses carry a two-byte, 16-bit byte address after the op-code.
// - each written byte commits as soon as shifted in, no busy period.
// - works in clock modes zero-zero and one-one only.
// - transfers are whole bytes, most significant bit first.
// - first byte after select falls is the op-code; address and data follow.
// - one op-code per select assertion.
// - mode set by idle clock level at select fall; first bit on first rise.
`timescale 1ns/10ps
module spi_nv_memory_slave_port
  import spi_nv_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  input  wire logic              mosi,
  output logic                   miso_o,
  output logic                   miso_oe,
  output logic                   selected,
  output logic                   wr_pulse,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_data
);

  frame_t fr_reg, fr_next;
  keep_t  kp_reg, kp_next;

  logic [ADDR_W-1:0] rd_addr_a;
  logic [ADDR_W-1:0] rd_addr_b;
  logic [7:0]        rd_data_a;
  logic [7:0]        rd_data_b;
  logic              out_want;
  logic              out_bit;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic              frame_rst;
  logic [7:0]        in_byte;
  logic [7:0]        status;
  logic              byte_done;

  // a select edge during pause is ignored, so the frame only clears with pause released
  assign frame_rst = rst | (cs_n & hold_n);

  assign in_byte   = {fr_reg.shift[6:0], mosi};
  assign byte_done = (fr_reg.bits == BIT_LAST);

  // both read ports look ahead, so the byte is ready before its first falling edge
  assign rd_addr_a = {fr_reg.addr[15:8], in_byte};
  assign rd_addr_b = fr_reg.addr + 16'h0001;

  always_comb begin
    status          = SR_FIXED;
    status[SR_WPEN] = kp_reg.wpen;
    status[SR_BP1]  = kp_reg.bp[1];
    status[SR_BP0]  = kp_reg.bp[0];
    status[SR_WEL]  = kp_reg.wel;
  end

  // rising-edge logic of the serial link
  always_comb begin
    fr_next = fr_reg;
    kp_next = kp_reg;
    mem_we  = 1'b0;
    mem_wa  = fr_reg.addr;
    mem_wd  = in_byte;
    if (hold_n) begin
      fr_next.bits  = fr_reg.bits + 3'h1;
      fr_next.shift = in_byte;
      if (byte_done) begin
        case (fr_reg.phase)
          PH_OPCODE: begin
            fr_next.opcode = in_byte;
            if (kp_reg.wr_pend) begin
              kp_next.wel     = 1'b0;
              kp_next.wr_pend = 1'b0;
            end
            case (in_byte)
              OP_WREN: begin
                kp_next.wel   = 1'b1;
                fr_next.phase = PH_IGNORE;
              end
              OP_WRDI: begin
                kp_next.wel   = 1'b0;
                fr_next.phase = PH_IGNORE;
              end
              OP_RDSR: begin
                fr_next.rd_byte      = status;
                fr_next.rd_byte[SR_WEL] = kp_reg.wel & ~kp_reg.wr_pend;
                fr_next.phase        = PH_STAT_OUT;
              end
              OP_WRSR:  fr_next.phase = PH_STAT_IN;
              OP_READ:  fr_next.phase = PH_ADDR_HI;
              OP_WRITE: fr_next.phase = PH_ADDR_HI;
              default:  fr_next.phase = PH_IGNORE;
            endcase
          end
          PH_ADDR_HI: begin
            fr_next.addr[15:8] = in_byte;
            fr_next.phase      = PH_ADDR_LO;
          end
          PH_ADDR_LO: begin
            fr_next.addr[7:0] = in_byte;
            fr_next.rd_byte   = rd_data_a;
            fr_next.phase     = PH_DATA;
          end
          PH_DATA: begin
            if (fr_reg.opcode == OP_WRITE && kp_reg.wel) begin
              mem_we            = 1'b1;
              kp_next.wr_pend   = 1'b1;
              kp_next.wr_tog    = ~kp_reg.wr_tog;
              kp_next.last_addr = fr_reg.addr;
              kp_next.last_data = in_byte;
            end
            fr_next.addr    = fr_reg.addr + 16'h0001;
            fr_next.rd_byte = rd_data_b;
          end
          PH_STAT_IN: begin
            if (kp_reg.wel && wp_n) begin
              kp_next.wpen    = in_byte[SR_WPEN];
              kp_next.bp      = {in_byte[SR_BP1], in_byte[SR_BP0]};
              kp_next.wr_pend = 1'b1;
            end
            fr_next.phase = PH_IGNORE;
          end
          PH_STAT_OUT: fr_next.rd_byte = status;
          PH_IGNORE:   fr_next.phase   = PH_IGNORE;
          default:     fr_next.phase   = PH_IGNORE;
        endcase
      end
    end
  end

  // counter restarts at every select, so the first rise carries bit 7 in either mode
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      fr_reg <= '{phase: PH_OPCODE, default: '0};
    end else begin
      fr_reg <= fr_next;
    end
  end

  // static logic: nothing here depends on a free-running serial clock
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      kp_reg <= '0;
    end else begin
      kp_reg <= kp_next;
    end
  end

  // array has no reset, its contents persist like the nonvolatile cells
  byte_store u_store (
    .sck  (sck),
    .we   (mem_we),
    .wa   (mem_wa),
    .wd   (mem_wd),
    .ra_a (rd_addr_a),
    .ra_b (rd_addr_b),
    .rd_a (rd_data_a),
    .rd_b (rd_data_b)
  );

  assign out_want = (fr_reg.phase == PH_DATA && fr_reg.opcode == OP_READ) ||
                    (fr_reg.phase == PH_STAT_OUT);
  assign out_bit  = fr_reg.rd_byte[3'(BIT_MSB - fr_reg.bits)];

  serial_out_stage u_out (
    .sck       (sck),
    .frame_rst (frame_rst),
    .hold_n    (hold_n),
    .cs_n      (cs_n),
    .want      (out_want),
    .bit_in    (out_bit),
    .miso_o    (miso_o),
    .miso_oe   (miso_oe)
  );

  sys_side_view u_sys (
    .clk       (clk),
    .rst       (rst),
    .cs_n      (cs_n),
    .wr_tog    (kp_reg.wr_tog),
    .last_addr (kp_reg.last_addr),
    .last_data (kp_reg.last_data),
    .selected  (selected),
    .wr_pulse  (wr_pulse),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

endmodule // spi_nv_memory_slave_port

// one write port on the serial clock, two look-ahead read ports
module byte_store
  import spi_nv_pkg::*;
(
  input  wire logic              sck,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] wa,
  input  wire logic [BYTE_W-1:0] wd,
  input  wire logic [ADDR_W-1:0] ra_a,
  input  wire logic [ADDR_W-1:0] ra_b,
  output logic      [BYTE_W-1:0] rd_a,
  output logic      [BYTE_W-1:0] rd_b
);

  logic [BYTE_W-1:0] cells [0:MEM_DEPTH-1];

  always_ff @(posedge sck) begin
    if (we) begin
      cells[wa] <= wd;
    end
  end

  assign rd_a = cells[ra_a];
  assign rd_b = cells[ra_b];

endmodule // byte_store

// falling-edge output stage of the link
module serial_out_stage
  import spi_nv_pkg::*;
(
  input  wire logic sck,
  input  wire logic frame_rst,
  input  wire logic hold_n,
  input  wire logic cs_n,
  input  wire logic want,
  input  wire logic bit_in,
  output logic      miso_o,
  output logic      miso_oe
);

  out_t out_reg, out_next;

  // a paused frame keeps its driver state, so the interrupted bit reappears on resume
  always_comb begin
    out_next = out_reg;
    if (hold_n) begin
      out_next.oe = want;
      out_next.q  = bit_in;
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  // pause gates the driver at once, not at the next clock edge
  assign miso_oe = out_reg.oe & hold_n & ~cs_n;
  assign miso_o  = out_reg.q;

endmodule // serial_out_stage

// system-side view: select level and write events cross by two-flop and toggle
module sys_side_view
  import spi_nv_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic              wr_tog,
  input  wire logic [ADDR_W-1:0] last_addr,
  input  wire logic [BYTE_W-1:0] last_data,
  output logic                   selected,
  output logic                   wr_pulse,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [BYTE_W-1:0] wr_data
);

  sys_t sys_reg, sys_next;

  always_comb begin
    sys_next          = sys_reg;
    sys_next.cs_sync  = {sys_reg.cs_sync[0], ~cs_n};
    sys_next.tog_sync = {sys_reg.tog_sync[1:0], wr_tog};
    sys_next.wr_pulse = sys_reg.tog_sync[2] ^ sys_reg.tog_sync[1];
    // last write is stable for a whole byte time, far longer than the sync delay
    if (sys_reg.tog_sync[2] ^ sys_reg.tog_sync[1]) begin
      sys_next.wr_addr = last_addr;
      sys_next.wr_data = last_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_reg <= '0;
    end else begin
      sys_reg <= sys_next;
    end
  end

  assign selected = sys_reg.cs_sync[1];
  assign wr_pulse = sys_reg.wr_pulse;
  assign wr_addr  = sys_reg.wr_addr;
  assign wr_data  = sys_reg.wr_data;

endmodule // sys_side_view

// *** spi_nv_memory_slave_port_properties.sv ***
`timescale 1ns/10ps
module spi_nv_memory_slave_port_properties
  import spi_nv_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        hold_n,
  input wire logic        miso_o,
  input wire logic        miso_oe,
  input wire logic        selected,
  input wire logic        wr_pulse,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0]  wr_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_off_desel: assert property (cs_n |-> !miso_oe) else $error("miso driven while idle");
  a_oe_off_pause: assert property (!hold_n |-> !miso_oe) else $error("miso driven in pause");
  a_oe_needs_sel: assert property (miso_oe |-> selected) else $error("miso driven unselected");
  a_sel_on_fall: assert property ($fell(cs_n) |-> ##[1:3] selected) else $error("select late");
  a_sel_off_rise: assert property ($rose(cs_n) && hold_n |-> ##[1:3] !selected) else $error("deselect late");
  a_pulse_one: assert property (wr_pulse |=> !wr_pulse) else $error("pulse too long");
  a_wr_hold_val: assert property (!wr_pulse |-> $stable(wr_addr) && $stable(wr_data)) else $error("wr moved");
  // output only moves after a falling serial edge
  a_miso_on_low: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck) else $error("miso edge");
  a_quiet_idle: assert property (cs_n [*6] |-> !wr_pulse) else $error("write while idle");
  c_write: cover property (wr_pulse);
  c_read: cover property (miso_oe);
  c_pause: cover property (!hold_n && !cs_n);
endmodule // spi_nv_memory_slave_port_properties
bind spi_nv_memory_slave_port spi_nv_memory_slave_port_properties u_props (
  .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe),
  .selected(selected), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));

// *** spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      hold_n,
  output logic      wp_n,
  output logic      mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  initial begin
    sck <= 0;
    cs_n <= 1;
    hold_n <= 1;
    wp_n <= 1;
    mosi <= 0;
  end
  // offset keeps link edges off the system clock edges
  task automatic start(input logic cpol);
    #1.1 sck <= cpol;
    #40 cs_n <= 0;
    #40;
  endtask
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, input int hold_at = 9);
    for (int i = 7; i >= 0; i--) begin
      sck <= 0;
      mosi <= tx[i];
      #40;
      if (i == hold_at) begin
        hold_n <= 0;
        #40 sck <= 1;
        #40 sck <= 0;
        #40 hold_n <= 1;
        #40;
      end
      sck <= 1;
      rx[i] = miso_oe ? miso_o : 1'bx;
      #40;
    end
  endtask
  // clock stands still between frames; released data line flips
  task automatic stop(input logic cpol);
    sck <= cpol;
    #40 cs_n <= 1;
    mosi <= ~mosi;
    #80;
  endtask
endmodule // spi_host_model

// *** spi_nv_memory_slave_port_tb_top.sv ***
`timescale 1ns/10ps
module spi_nv_memory_slave_port_tb_top
  import spi_nv_pkg::*;
;
  logic        clk = 0;
  logic        rst = 0;
  wire logic   sck, cs_n, hold_n, wp_n, mosi;
  logic        miso_o, miso_oe, selected, wr_pulse;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data, got;
  logic [7:0]  tx[2], rx[2];
  int          fail_count = 0, num_checks = 0, n_pulse = 0;
  always #2.5 clk = ~clk;
  spi_host_model host (.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe));
  spi_nv_memory_slave_port DUT (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
    .wp_n(wp_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .selected(selected),
    .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));
  always @(posedge clk) if (wr_pulse === 1'b1) n_pulse <= n_pulse + 1;
  task automatic chk(input string nm, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic sr(input logic [7:0] op, d);
    host.start(0);
    host.xbyte(op, got);
    host.xbyte(d, got);
    host.stop(0);
  endtask
  task automatic mem(input logic cpol, input logic [7:0] op, input logic [15:0] a, input int n, hold_at);
    host.start(cpol);
    host.xbyte(op, got);
    host.xbyte(a[15:8], got);
    host.xbyte(a[7:0], got);
    for (int i = 0; i < n; i++) host.xbyte(tx[i], rx[i], hold_at);
    host.stop(cpol);
  endtask
  task automatic t_write_wrap;
    sr(OP_WREN, 8'h00);
    tx = '{8'hA5, 8'h3C};
    mem(0, OP_WRITE, 16'hFFFF, 2, 9);
    chk("pulses", 16'h0002, 16'(n_pulse));
    chk("wr_addr", 16'h0000, wr_addr);
    chk("wr_data", 8'h3C, wr_data);
    mem(1, OP_READ, 16'hFFFF, 2, 9);
    chk("rd0", 8'hA5, rx[0]);
    chk("rd1", 8'h3C, rx[1]);
  endtask
  task automatic t_refuse;
    tx[0] = 8'h00;
    mem(0, OP_WRITE, 16'hFFFF, 1, 9);
    chk("pulses", 16'h0002, 16'(n_pulse));
    mem(0, OP_READ, 16'hFFFF, 1, 9);
    chk("rd0", 8'hA5, rx[0]);
  endtask
  task automatic t_protect;
    host.wp_n <= 0;
    sr(OP_WREN, 8'h00);
    sr(OP_WRSR, 8'h8C);
    sr(OP_RDSR, 8'h00);
    chk("status", 8'h42, got);
    host.wp_n <= 1;
    sr(OP_WRSR, 8'h8C);
    sr(OP_RDSR, 8'h00);
    chk("status", 8'hCC, got);
    host.wp_n <= 0;
    sr(OP_WREN, 8'h00);
    tx[0] = 8'h5A;
    mem(0, OP_WRITE, 16'h1234, 1, 9);
    chk("wr_data", 8'h5A, wr_data);
  endtask
  task automatic t_pause;
    mem(0, OP_READ, 16'h1234, 1, 3);
    chk("rd_pause", 8'h5A, rx[0]);
  endtask
  task automatic t_disable;
    sr(OP_WREN, 8'h00);
    sr(OP_WRDI, 8'h00);
    sr(OP_RDSR, 8'h00);
    chk("status", 8'hCC, got);
    tx[0] = 8'hFF;
    mem(1, OP_WRITE, 16'h1234, 1, 9);
    chk("pulses", 16'h0003, 16'(n_pulse));
    mem(0, OP_READ, 16'h1234, 1, 9);
    chk("rd_kept", 8'h5A, rx[0]);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk("miso_oe", 1'b0, miso_oe);
    chk("selected", 1'b0, selected);
    t_write_wrap();
    t_refuse();
    t_protect();
    t_pause();
    t_disable();
    wrap_up();
  end
  // the sequence needs about an eighth of this span
  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end
endmodule // spi_nv_memory_slave_port_tb_top
